// ===== hdl/ppp_parallel_port.sv
// Purpose: parallel printer port reached through three i/o ports
// Assumes: i/o strobes synchronous to mclk, one cycle each
// Notes: read data is registered and valid the cycle after ioRd
`timescale 1ns/100ps

// What this block does
// - eight data, four control, five status lines
// - write data, read data, read status
// - drive active-low auto line feed
// - drive active-low initialise output
// - drive active-low select-input output
// - data writes taken even while busy active
// - device pulses receipt, then ready again
// - data port write takes bus byte
// - captured byte appears on data lines
// - status read returns live status lines
// - status bits 0 to 2 unused
// - command bit 0 drives strobe
module ppp_parallel_port (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [15:0] ioAddr,
  input wire logic ioWr,
  input wire logic ioRd,
  input wire logic [7:0] ioWrData,
  output logic [7:0] ioRdData,
  output logic [7:0] lineDataOut,
  output logic lineDataOe,
  input wire logic [7:0] lineDataIn,
  output ppp_pkg::ppp_control_t lineCtrl,
  input wire ppp_pkg::ppp_status_t lineStatus
);
  import ppp_pkg::*;

  logic [7:0] outputByte_reg;
  logic [4:0] lineCommand_reg;
  logic [7:0] ioRdData_reg;
  logic [7:0] ioRdData_next;
  logic [7:0] dataSync1_reg;
  logic [7:0] dataSync2_reg;
  logic [7:0] dataSync3_reg;
  logic [7:0] dataStable_reg;
  logic [4:0] statSync1_reg;
  logic [4:0] statSync2_reg;
  logic [4:0] statSync3_reg;
  logic [4:0] statStable_reg;
  logic selData;
  logic selStat;
  logic selCmd;
  logic selNone;

  assign selData = (ioAddr == OUTPUT_BYTE_PORT_ADDR);
  assign selStat = (ioAddr == LINE_CONDITION_PORT_ADDR);
  assign selCmd = (ioAddr == LINE_COMMAND_PORT_ADDR);
  // unmapped addresses read as all ones and ignore writes
  assign selNone = !selData && !selStat && !selCmd;

  // data latch
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      outputByte_reg <= OUTPUT_BYTE_RESET;
    else if (ioWr && selData)
      outputByte_reg <= ioWrData;
  end

  // command latch; strobe width is left to software timing
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      lineCommand_reg <= LINE_COMMAND_RESET;
    else if (ioWr && selCmd)
      lineCommand_reg <= ioWrData[4:0];
  end

  // outputs: command bits are active high, lines active low
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      lineDataOut <= OUTPUT_BYTE_RESET;
      lineDataOe <= 1'b1;
      lineCtrl <= '{1'b1, 1'b1, 1'b1, 1'b1};
    end
    else
    begin
      lineDataOut <= (ioWr && selData) ? ioWrData : outputByte_reg;
      lineDataOe <= 1'b1;
      lineCtrl.strobe_n <= ~((ioWr && selCmd) ? ioWrData[CMD_STROBE_BIT]
                                              : lineCommand_reg[CMD_STROBE_BIT]);
      lineCtrl.autoFeed_n <= ~((ioWr && selCmd) ? ioWrData[CMD_AUTO_BIT]
                                                : lineCommand_reg[CMD_AUTO_BIT]);
      lineCtrl.init_n <= ~((ioWr && selCmd) ? ioWrData[CMD_INIT_BIT]
                                            : lineCommand_reg[CMD_INIT_BIT]);
      lineCtrl.selectIn_n <= ~((ioWr && selCmd) ? ioWrData[CMD_SELECT_BIT]
                                                : lineCommand_reg[CMD_SELECT_BIT]);
    end
  end

  // pin inputs: three flops, change accepted when second and third agree
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      dataSync1_reg <= 8'h00;
      dataSync2_reg <= 8'h00;
      dataSync3_reg <= 8'h00;
      dataStable_reg <= 8'h00;
    end
    else
    begin
      dataSync1_reg <= lineDataIn;
      dataSync2_reg <= dataSync1_reg;
      dataSync3_reg <= dataSync2_reg;
      for (int i = 0; i < 8; i++)
        if (dataSync2_reg[i] == dataSync3_reg[i])
          dataStable_reg[i] <= dataSync3_reg[i];
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      statSync1_reg <= 5'h00;
      statSync2_reg <= 5'h00;
      statSync3_reg <= 5'h00;
      statStable_reg <= 5'h00;
    end
    else
    begin
      statSync1_reg <= lineStatus;
      statSync2_reg <= statSync1_reg;
      statSync3_reg <= statSync2_reg;
      for (int i = 0; i < 5; i++)
        if (statSync2_reg[i] == statSync3_reg[i])
          statStable_reg[i] <= statSync3_reg[i];
    end
  end

  // read mux; data port reads back the pins, so a loopback shows the latch
  always_comb
  begin
    ioRdData_next = ioRdData_reg;
    if (ioRd)
    begin
      if (selData)
        ioRdData_next = dataStable_reg;
      else if (selStat)
        ioRdData_next = {statStable_reg, 3'b000};
      else if (selCmd)
        ioRdData_next = {3'b000, lineCommand_reg};
      else
        ioRdData_next = UNMAPPED_READ;
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      ioRdData_reg <= 8'h00;
    else
      ioRdData_reg <= ioRdData_next;
  end

  assign ioRdData = ioRdData_reg;

  // checks
  sequence cmdWrite_s(int bitPos, logic val);
    ioWr && selCmd && (ioWrData[bitPos] == val);
  endsequence

  sequence statusRead_s;
    ioRd && selStat;
  endsequence

  sequence noCmdWrite_s;
    !(ioWr && selCmd);
  endsequence

  dataLatchLoad_a: assert property (@(posedge mclk) disable iff (reset)
    ioWr && selData |=> lineDataOut == $past(ioWrData))
    else $error("data lines do not show written byte");
  dataLatchHold_a: assert property (@(posedge mclk) disable iff (reset)
    !(ioWr && selData) |=> outputByte_reg == $past(outputByte_reg))
    else $error("data latch changed without write");
  strobeDrive_a: assert property (@(posedge mclk) disable iff (reset)
    cmdWrite_s(CMD_STROBE_BIT, 1'b1) |=> !lineCtrl.strobe_n)
    else $error("strobe not asserted by command write");
  autoDrive_a: assert property (@(posedge mclk) disable iff (reset)
    cmdWrite_s(CMD_AUTO_BIT, 1'b0) |=> lineCtrl.autoFeed_n)
    else $error("auto feed not released");
  initDrive_a: assert property (@(posedge mclk) disable iff (reset)
    cmdWrite_s(CMD_INIT_BIT, 1'b1) |=> !lineCtrl.init_n)
    else $error("init not asserted");
  // pins and latch load on the same edge, so they always agree
  selectDrive_a: assert property (@(posedge mclk) disable iff (reset)
    lineCtrl.selectIn_n == !lineCommand_reg[CMD_SELECT_BIT])
    else $error("select input mismatch");
  strobeMatch_a: assert property (@(posedge mclk) disable iff (reset)
    lineCtrl.strobe_n == !lineCommand_reg[CMD_STROBE_BIT])
    else $error("strobe differs from latch");
  autoMatch_a: assert property (@(posedge mclk) disable iff (reset)
    lineCtrl.autoFeed_n == !lineCommand_reg[CMD_AUTO_BIT])
    else $error("auto feed differs from latch");
  initMatch_a: assert property (@(posedge mclk) disable iff (reset)
    lineCtrl.init_n == !lineCommand_reg[CMD_INIT_BIT])
    else $error("init differs from latch");

  strobeRelease_a: assert property (@(posedge mclk) disable iff (reset)
    cmdWrite_s(CMD_STROBE_BIT, 1'b0) |=> lineCtrl.strobe_n)
    else $error("strobe not released by command write");
  autoAssert_a: assert property (@(posedge mclk) disable iff (reset)
    cmdWrite_s(CMD_AUTO_BIT, 1'b1) |=> !lineCtrl.autoFeed_n)
    else $error("auto feed not asserted");
  initRelease_a: assert property (@(posedge mclk) disable iff (reset)
    cmdWrite_s(CMD_INIT_BIT, 1'b0) |=> lineCtrl.init_n)
    else $error("init not released");
  selectAssert_a: assert property (@(posedge mclk) disable iff (reset)
    cmdWrite_s(CMD_SELECT_BIT, 1'b1) |=> !lineCtrl.selectIn_n)
    else $error("select input not asserted");
  selectRelease_a: assert property (@(posedge mclk) disable iff (reset)
    cmdWrite_s(CMD_SELECT_BIT, 1'b0) |=> lineCtrl.selectIn_n)
    else $error("select input not released");
  cmdLatchLoad_a: assert property (@(posedge mclk) disable iff (reset)
    ioWr && selCmd |=> lineCommand_reg == $past(ioWrData[4:0]))
    else $error("command write lost");

  // latches and pins only move on their own port write
  ctrlHold_a: assert property (@(posedge mclk) disable iff (reset)
    noCmdWrite_s |=> $stable(lineCtrl))
    else $error("control lines changed without write");
  cmdLatchHold_a: assert property (@(posedge mclk) disable iff (reset)
    noCmdWrite_s |=> $stable(lineCommand_reg))
    else $error("command latch changed without write");
  dataLineHold_a: assert property (@(posedge mclk) disable iff (reset)
    !(ioWr && selData) |=> $stable(lineDataOut))
    else $error("data lines changed without write");
  writeIgnored_a: assert property (@(posedge mclk) disable iff (reset)
    ioWr && selNone |=> $stable(outputByte_reg) && $stable(lineCommand_reg))
    else $error("unmapped write changed a latch");

  // read side
  dataRead_a: assert property (@(posedge mclk) disable iff (reset)
    ioRd && selData |=> ioRdData == $past(dataStable_reg))
    else $error("data read wrong");
  cmdRead_a: assert property (@(posedge mclk) disable iff (reset)
    ioRd && selCmd |=> ioRdData == {3'b000, $past(lineCommand_reg)})
    else $error("command read wrong");
  unmappedRead_a: assert property (@(posedge mclk) disable iff (reset)
    ioRd && selNone |=> ioRdData == UNMAPPED_READ)
    else $error("unmapped read wrong");
  readHold_a: assert property (@(posedge mclk) disable iff (reset)
    !ioRd |=> $stable(ioRdData))
    else $error("read data changed without read");
  statusUnused_a: assert property (@(posedge mclk) disable iff (reset)
    statusRead_s |=> ioRdData[2:0] == 3'b000)
    else $error("unused status bits set");
  statusBusyBit_a: assert property (@(posedge mclk) disable iff (reset)
    statusRead_s |=> ioRdData[7] == $past(statStable_reg[4]))
    else $error("busy bit misplaced");

  // filters: a level is taken once two stages agree
  statusSync_a: assert property (@(posedge mclk) disable iff (reset)
    statSync2_reg == statSync3_reg |=> statStable_reg == $past(statSync3_reg))
    else $error("status filter did not follow");
  dataSync_a: assert property (@(posedge mclk) disable iff (reset)
    dataSync2_reg == dataSync3_reg |=> dataStable_reg == $past(dataSync3_reg))
    else $error("data filter did not follow");
  resetData_a: assert property (@(posedge mclk)
    $fell(reset) |-> lineDataOut == OUTPUT_BYTE_RESET && ioRdData == 8'h00)
    else $error("data or read value wrong after reset");
  statusRead_a: assert property (@(posedge mclk) disable iff (reset)
    ioRd && selStat |=> ioRdData[7:3] == $past(statStable_reg) && ioRdData[2:0] == 3'b000)
    else $error("status read wrong");
  dataDrive_a: assert property (@(posedge mclk) disable iff (reset)
    lineDataOe)
    else $error("data lines not driven");
  dataWrite_a: assert property (@(posedge mclk) disable iff (reset)
    ioWr && selData |=> outputByte_reg == $past(ioWrData))
    else $error("data port write lost");
  resetIdle_a: assert property (@(posedge mclk)
    $fell(reset) |-> lineCtrl.strobe_n && lineCtrl.init_n && lineCtrl.selectIn_n)
    else $error("controls active after reset");
endmodule : ppp_parallel_port

// ===== hdl/ppp_pkg.sv
// Purpose: shared constants and carriers for the parallel printer port
// Assumes: 8-bit i/o bus, 16-bit i/o addresses
// Notes: status and command bit positions follow the port byte layout
package ppp_pkg;
  localparam logic [15:0] OUTPUT_BYTE_PORT_ADDR = 16'h0378;
  localparam logic [15:0] LINE_CONDITION_PORT_ADDR = 16'h0379;
  localparam logic [15:0] LINE_COMMAND_PORT_ADDR = 16'h037A;
  localparam logic [7:0] OUTPUT_BYTE_RESET = 8'h00;
  localparam logic [4:0] LINE_COMMAND_RESET = 5'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'hFF;
  // command bits
  localparam int CMD_STROBE_BIT = 0;
  localparam int CMD_AUTO_BIT = 1;
  localparam int CMD_INIT_BIT = 2;
  localparam int CMD_SELECT_BIT = 3;
  localparam int CMD_IRQEN_BIT = 4;
  // least strobe width
  localparam int CLOCK_HZ = 20000000;
  localparam int STROBE_MIN_NS = 500;
  localparam int STROBE_MIN_CYCLES = (STROBE_MIN_NS * (CLOCK_HZ / 1000000) + 999) / 1000;

  typedef struct packed {
    logic busy;
    logic receiptPulse_n;
    logic noMedia;
    logic selected;
    logic fault_n;
  } ppp_status_t;

  typedef struct packed {
    logic strobe_n;
    logic autoFeed_n;
    logic init_n;
    logic selectIn_n;
  } ppp_control_t;
endpackage : ppp_pkg

// ===== verification/ppp_printer_model.sv
// Purpose: behavioural printer on the far side of the port
// Assumes: strobe_n low for several mclk cycles per byte
// Notes: paperOut is commanded by the bench only
`timescale 1ns/100ps
module ppp_printer_model (
  input wire logic mclk,
  input wire ppp_pkg::ppp_control_t ctrl,
  input wire logic [7:0] data,
  input wire logic paperOut,
  output ppp_pkg::ppp_status_t status,
  output logic [7:0] gotByte,
  output logic [7:0] lastLow
);
  import ppp_pkg::*;
  logic [3:0] cnt;
  logic strobeLow;
  logic [7:0] lowCnt;
  initial
  begin
    cnt = 4'h0;
    gotByte = 8'h00;
    strobeLow = 1'b0;
    lowCnt = 8'h00;
    lastLow = 8'h00;
  end
  // length of the last strobe pulse in mclk cycles
  always @(posedge mclk)
  begin
    if (!ctrl.strobe_n)
      lowCnt <= lowCnt + 8'h01;
    else if (strobeLow)
    begin
      lastLow <= lowCnt;
      lowCnt <= 8'h00;
    end
  end
  // one byte per strobe; later strobes ignored until receipt ends
  always @(posedge mclk)
  begin
    if (!ctrl.strobe_n && !strobeLow && cnt == 4'h0)
    begin
      gotByte <= data;
      cnt <= 4'hF;
    end
    else if (cnt != 4'h0)
      cnt <= cnt - 4'h1;
    strobeLow <= !ctrl.strobe_n;
  end
  // busy, receipt, no-media, selected, fault_n
  assign status = {(cnt > 4'h4) || paperOut,
    !(cnt inside {[4'h1:4'h4]}),
    paperOut, !ctrl.selectIn_n, !paperOut};
endmodule : ppp_printer_model

// ===== verification/testbench.sv
// Purpose: self-checking bench for the parallel printer port
// Assumes: one-cycle i/o strobes driven at the falling edge
// Notes: status reads wait out the pin synchronisers
`timescale 1ns/100ps
module testbench;
  import ppp_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [15:0] ioAddr = 16'h0000;
  logic ioWr = 1'b0;
  logic ioRd = 1'b0;
  logic [7:0] ioWrData = 8'h00;
  logic [7:0] ioRdData, lineDataOut, gotByte, lastLow;
  logic lineDataOe;
  logic paperOut = 1'b0;
  ppp_control_t lineCtrl;
  ppp_status_t lineStatus;
  int failures = 0;
  int samples_checked = 0;
  always #25 mclk = ~mclk;
  ppp_parallel_port u_dut (.mclk(mclk), .reset(reset), .ioAddr(ioAddr), .ioWr(ioWr),
    .ioRd(ioRd), .ioWrData(ioWrData), .ioRdData(ioRdData), .lineDataOut(lineDataOut),
    .lineDataOe(lineDataOe), .lineDataIn(lineDataOe ? lineDataOut : 8'h5A),
    .lineCtrl(lineCtrl), .lineStatus(lineStatus));
  ppp_printer_model u_prn (.mclk(mclk), .ctrl(lineCtrl), .data(lineDataOut),
    .paperOut(paperOut), .status(lineStatus), .gotByte(gotByte), .lastLow(lastLow));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk);
    {ioAddr, ioWrData, ioWr} = {a, d, 1'b1};
    @(negedge mclk);
    ioWr = 1'b0;
    @(negedge mclk);
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge mclk);
    {ioAddr, ioRd} = {a, 1'b1};
    @(negedge mclk);
    ioRd = 1'b0;
    @(negedge mclk);
    d = ioRdData;
  endtask : rd
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test
  // generous against a run of about 105 cycles
  initial
  begin
    repeat (5000) @(posedge mclk);
    failures++;
    end_of_test();
  end
  initial
  begin
    logic [7:0] v;
    repeat (16) @(negedge mclk);
    reset = 1'b0;
    check({4'h0, lineCtrl}, 8'h0F);
    check(lineDataOut, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 4; i++)
    begin
      wr(LINE_COMMAND_PORT_ADDR, 8'h01 << i);
      check({4'h0, lineCtrl}, 8'h0F & ~(8'h08 >> i));
    end
    $display("command test done");
    repeat (20) @(negedge mclk);
    wr(OUTPUT_BYTE_PORT_ADDR, 8'hA5);
    check(lineDataOut, 8'hA5);
    wr(LINE_COMMAND_PORT_ADDR, 8'h0D);
    repeat (10) @(negedge mclk);
    wr(LINE_COMMAND_PORT_ADDR, 8'h0C);
    check(gotByte, 8'hA5);
    check({7'h00, lastLow >= 8'(STROBE_MIN_CYCLES)}, 8'h01);
    check({4'h0, lineCtrl}, 8'h0C);
    rd(OUTPUT_BYTE_PORT_ADDR, v);
    check(v, 8'hA5);
    repeat (20) @(negedge mclk);
    rd(LINE_CONDITION_PORT_ADDR, v);
    check(v, 8'h58);
    $display("transfer test done");
    paperOut = 1'b1;
    repeat (6) @(negedge mclk);
    rd(LINE_CONDITION_PORT_ADDR, v);
    check(v, 8'hF0);
    rd(16'h037B, v);
    check(v, UNMAPPED_READ);
    $display("status test done");
    end_of_test();
  end
endmodule : testbench
